//--- verilog/sacr_pkg.sv
// Shared constants and types of the converter control and serial readout.
// Assumes a 100 MHz core clock; every user writes sacr_pkg::name.
package sacr_pkg;

	// ****************************************************************
	// Word format and core timing
	// ****************************************************************
	localparam int RES_BITS      = 18;
	localparam int MCLK_MHZ      = 100;
	// Conversion time in ns; the internal oscillator is the core clock.
	localparam int CONV_TIME_NS  = 460;
	// A least time, so the cycle count rounds up.
	localparam int CONV_CYCLES   = (CONV_TIME_NS * MCLK_MHZ + 999) / 1000;
	localparam int STEP_CYCLES   = CONV_CYCLES / RES_BITS;
	localparam int SETTLE_CYCLES = CONV_CYCLES - RES_BITS * STEP_CYCLES;
	localparam int BUF_DEPTH     = 2;

	// ****************************************************************
	// Reset values and field positions
	// ****************************************************************
	localparam logic [17:0] WORD_RESET  = 18'h0_0000;
	localparam logic [17:0] MSB_MASK    = 18'h2_0000;
	localparam int          SIGN_POS    = 17;
	localparam logic [5:0]  SCK_CNT_MAX = 6'h3F;

	// Conversion sequencer states.
	typedef enum logic [1:0] {S_NAP, S_SETTLE, S_STEP, S_DONE} sacr_conv_state_type;
	typedef logic [17:0] sacr_word_type;

endpackage : sacr_pkg

//--- verilog/sacr_word_if.sv
// Valid/ready word carrier between the sequencer, the buffer and the top.
// Assumes both ends run on the core clock.
`timescale 1ns/100ps
interface sacr_word_if;
	logic                   valid;
	logic                   ready;
	sacr_pkg::sacr_word_type data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sacr_word_if

//--- verilog/sacr_pair_buf.sv
// Two-entry flip-flop buffer with valid and ready on both sides.
// Assumes a single clock domain for both sides.
`timescale 1ns/100ps
module sacr_pair_buf #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Filling and draining sides.
	sacr_word_if.snk fill,
	sacr_word_if.src drain
);
	logic [WIDTH-1:0]         mem_r [DEPTH];
	logic [$clog2(DEPTH)-1:0] wr_r;
	logic [$clog2(DEPTH)-1:0] rd_r;
	logic [$clog2(DEPTH):0]   cnt_r;
	wire                      push;
	wire                      pop;

	// Honest full and empty: ready drops when both entries hold words.
	assign fill.ready  = (cnt_r != ($clog2(DEPTH)+1)'(DEPTH));
	assign drain.valid = (cnt_r != '0);
	assign drain.data  = mem_r[rd_r];
	assign push        = fill.valid & fill.ready;
	assign pop         = drain.valid & drain.ready;

	// Pointers wrap at the depth.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= (wr_r == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_r + (($clog2(DEPTH)+1)'(push)) - (($clog2(DEPTH)+1)'(pop));
		end
	end

	// Storage, one word per entry.
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++)
		begin : g_ent
			always_ff @(posedge clk)
			begin
				if (push && wr_r == ($clog2(DEPTH))'(g))
					mem_r[g] <= fill.data;
			end
		end
	endgenerate
endmodule : sacr_pair_buf

//--- verilog/sacr_sar_engine.sv
// Successive-approximation sequencer driving the capacitive DAC trial code.
// Assumes a comparator level latched one cycle after the trial code: high means input above trial.
`timescale 1ns/100ps
module sacr_sar_engine (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control.
	input  wire logic       start,
	input  wire logic       comp_hi,
	output logic            busy,
	output logic [17:0]     dac_code,
	// Result toward the buffer.
	sacr_word_if.src        res
);
	sacr_pkg::sacr_conv_state_type state_r;
	logic [17:0] dac_r;
	logic [17:0] mask_r;
	logic [3:0]  cnt_r;
	wire  [17:0] keep_code;
	wire         step_end;

	// Drop the trial bit when the input sits below the trial level.
	assign keep_code = comp_hi ? dac_r : (dac_r & ~mask_r);
	assign step_end  = (cnt_r == 4'h0);
	assign busy      = (state_r != sacr_pkg::S_NAP);
	assign dac_code  = dac_r;
	assign res.valid = (state_r == sacr_pkg::S_DONE);
	// Offset binary to two's complement: invert the top bit.
	assign res.data  = dac_r ^ sacr_pkg::MSB_MASK;

	// Sequencer: settle, then one trial per bit, MSB first.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= sacr_pkg::S_NAP;
			dac_r   <= sacr_pkg::WORD_RESET;
			mask_r  <= sacr_pkg::WORD_RESET;
			cnt_r   <= 4'h0;
		end
		else
		begin
			case (state_r)
				sacr_pkg::S_NAP:
					if (start)
					begin
						state_r <= sacr_pkg::S_SETTLE;
						cnt_r   <= 4'(sacr_pkg::SETTLE_CYCLES - 1);
					end
				sacr_pkg::S_SETTLE:
					if (step_end)
					begin
						state_r <= sacr_pkg::S_STEP;
						dac_r   <= sacr_pkg::MSB_MASK;
						mask_r  <= sacr_pkg::MSB_MASK;
						cnt_r   <= 4'(sacr_pkg::STEP_CYCLES - 1);
					end
					else
						cnt_r <= cnt_r - 4'h1;
				sacr_pkg::S_STEP:
					if (step_end)
					begin
						dac_r  <= keep_code | (mask_r >> 1);
						mask_r <= mask_r >> 1;
						cnt_r  <= 4'(sacr_pkg::STEP_CYCLES - 1);
						if (mask_r[0])
							state_r <= sacr_pkg::S_DONE;
					end
					else
						cnt_r <= cnt_r - 4'h1;
				default:
					if (res.ready)
						state_r <= sacr_pkg::S_NAP;
			endcase
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_trial_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(state_r == sacr_pkg::S_STEP) |-> dac_r == sacr_pkg::MSB_MASK && mask_r == sacr_pkg::MSB_MASK)
		else $error("First trial is not the top bit.");
	a_conv_length: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == sacr_pkg::S_NAP && start) |=> busy ##46 (state_r == sacr_pkg::S_DONE))
		else $error("Conversion did not last the oscillator time.");
endmodule : sacr_sar_engine

//--- verilog/sacr_top.sv
// Converter control and serial readout top: conversion sequencing on MCLK,
// result shifting on the host serial clock SCK.
// Assumes SCK stands still during conversion and pins are asynchronous to MCLK.
//
// What this block does
// - Convert strobe rising edge starts a conversion.
// - Chain select low: shared pin enables output.
// - Chain select high: shared pin is chain input.
// - Busy high during conversion, low when done.
// - Shift result MSB first on rising SCK.
// - Assemble 18-bit code at end of conversion.
// - Result coded in two's complement.
// - DAC walks an 18-bit binary search.
// - Conversion timed by internal clock, not SCK.
// - Read data belongs to the latest conversion.
// - Nap automatically between conversions.
// - Drive output after read enable falls.
`timescale 1ns/100ps
module sacr_top (
	// Core clock and reset.
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	// Conversion control pins.
	input  wire logic        CONVERT_STROBE,
	input  wire logic        CHAIN_SELECT,
	input  wire logic        READ_ENABLE_OR_CHAIN_IN,
	output logic             BUSY,
	output logic             NAP,
	// Analog core.
	input  wire logic        COMPARE_IN,
	output logic [17:0]      CAPACITIVE_DAC_CODE,
	// Serial link.
	input  wire logic        SCK,
	output logic             SDO_O,
	output logic             SDO_OE
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic        cnv_s1_r;
	logic        cnv_s2_r;
	logic        cnv_s3_r;
	logic        chain_s1_r;
	logic        chain_s2_r;
	logic        rdl_s1_r;
	logic        rdl_s2_r;
	logic        cmp_s1_r;
	logic        act_s1_r;
	logic        act_s2_r;
	logic        busy_r;
	logic        busy_nxt;
	logic        nap_r;
	logic        oe_r;
	logic        oe_nxt;
	logic [17:0] word_r;
	logic [17:0] last_res_r;
	wire         conv_edge;
	wire         eng_busy;
	wire         load_word;
	wire         sck_clr_n;
	logic [5:0]  sck_cnt_r;
	logic [17:0] chain_r;
	logic        read_act_r;
	wire  [4:0]  bit_sel;
	wire         own_phase;
	wire         sdo_bit;

	sacr_word_if eng_to_buf ();
	sacr_word_if buf_to_out ();

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Every control pin passes two flops; the third convert flop only feeds the edge detector.
	// The comparator answers the DAC code that MCLK drives, so it is latched once only.
	// A second flop would hand each two-cycle trial the decision on the previous trial.
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			cnv_s1_r   <= 1'b0;
			cnv_s2_r   <= 1'b0;
			cnv_s3_r   <= 1'b0;
			chain_s1_r <= 1'b0;
			chain_s2_r <= 1'b0;
			rdl_s1_r   <= 1'b1;
			rdl_s2_r   <= 1'b1;
			cmp_s1_r   <= 1'b0;
			act_s1_r   <= 1'b0;
			act_s2_r   <= 1'b0;
		end
		else
		begin
			cnv_s1_r   <= CONVERT_STROBE;
			cnv_s2_r   <= cnv_s1_r;
			cnv_s3_r   <= cnv_s2_r;
			chain_s1_r <= CHAIN_SELECT;
			chain_s2_r <= chain_s1_r;
			rdl_s1_r   <= READ_ENABLE_OR_CHAIN_IN;
			rdl_s2_r   <= rdl_s1_r;
			cmp_s1_r   <= COMPARE_IN;
			act_s1_r   <= read_act_r;
			act_s2_r   <= act_s1_r;
		end
	end

	// Only a rising edge starts work; a held high level does nothing more.
	assign conv_edge = cnv_s2_r & ~cnv_s3_r;

	// ****************************************************************
	// Conversion and result buffering
	// ****************************************************************
	// The sequencer runs on MCLK alone, so SCK activity never changes its length.
	sacr_sar_engine u_engine (
		.clk      (MCLK),
		.rst_n    (RST_N),
		.start    (conv_edge),
		.comp_hi  (cmp_s1_r),
		.busy     (eng_busy),
		.dac_code (CAPACITIVE_DAC_CODE),
		.res      (eng_to_buf.src)
	);

	// The buffer holds finished words while a read is still in progress.
	sacr_pair_buf #(
		.WIDTH (sacr_pkg::RES_BITS),
		.DEPTH (sacr_pkg::BUF_DEPTH)
	) u_buf (
		.clk   (MCLK),
		.rst_n (RST_N),
		.fill  (eng_to_buf.snk),
		.drain (buf_to_out.src)
	);

	// A word moves to the output register only while no frame is shifting.
	assign buf_to_out.ready = ~act_s2_r;
	assign load_word        = buf_to_out.valid & buf_to_out.ready;

	// Busy covers the conversion and the hand-over into the output register.
	assign busy_nxt = eng_busy | buf_to_out.valid;

	// Output drive: always in chain mode, by the low read enable otherwise.
	assign oe_nxt = chain_s2_r | ~rdl_s2_r;

	// ****************************************************************
	// Core-side state
	// ****************************************************************
	// Status flops and the word presented to the serial side.
	always_ff @(posedge MCLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			busy_r     <= 1'b0;
			nap_r      <= 1'b1;
			oe_r       <= 1'b0;
			word_r     <= sacr_pkg::WORD_RESET;
			last_res_r <= sacr_pkg::WORD_RESET;
		end
		else
		begin
			busy_r <= busy_nxt;
			nap_r  <= ~busy_nxt;
			oe_r   <= oe_nxt;
			if (load_word)
				word_r <= buf_to_out.data;
			if (eng_to_buf.valid && eng_to_buf.ready)
				last_res_r <= eng_to_buf.data;
		end
	end

	assign BUSY   = busy_r;
	assign NAP    = nap_r;
	assign SDO_OE = oe_r;

	// ****************************************************************
	// Serial clock domain
	// ****************************************************************
	// Each conversion clears the shift state, since SCK may not tick
	// between frames; the host keeps SCK quiet while busy is high.
	assign sck_clr_n = RST_N & ~busy_r;

	// Bit counter, upstream chain capture and read activity flag.
	always_ff @(posedge SCK or negedge sck_clr_n)
	begin
		if (!sck_clr_n)
		begin
			sck_cnt_r  <= 6'h00;
			chain_r    <= sacr_pkg::WORD_RESET;
			read_act_r <= 1'b0;
		end
		else
		begin
			if (sck_cnt_r != sacr_pkg::SCK_CNT_MAX)
				sck_cnt_r <= sck_cnt_r + 6'h01;
			chain_r    <= {chain_r[16:0], READ_ENABLE_OR_CHAIN_IN};
			read_act_r <= 1'b1;
		end
	end

	// The MSB stands on the pin before the first edge; each edge advances one bit.
	// Upstream bits follow the own word, delayed by the chain register.
	assign own_phase = (sck_cnt_r < 6'(sacr_pkg::RES_BITS));
	assign bit_sel   = 5'(sacr_pkg::SIGN_POS) - sck_cnt_r[4:0];
	assign sdo_bit   = own_phase ? word_r[bit_sel] : (chain_s2_r & chain_r[17]);
	assign SDO_O     = sdo_bit;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_busy_on_start: assert property (@(posedge MCLK) disable iff (!RST_N)
		(conv_edge && !eng_busy && !buf_to_out.valid) |=> ##1 busy_r)
		else $error("Busy did not rise after a convert edge.");
	a_busy_falls_done: assert property (@(posedge MCLK) disable iff (!RST_N)
		$fell(busy_r) |-> $past(!eng_busy) && !buf_to_out.valid)
		else $error("Busy fell with a conversion pending.");
	a_word_is_latest: assert property (@(posedge MCLK) disable iff (!RST_N)
		$fell(busy_r) |-> word_r == last_res_r)
		else $error("Output word is not the latest result.");
	a_sign_twos: assert property (@(posedge MCLK) disable iff (!RST_N)
		(eng_to_buf.valid) |-> eng_to_buf.data[17] == ~CAPACITIVE_DAC_CODE[17])
		else $error("Result sign bit not in two's complement.");
	a_nap_idle: assert property (@(posedge MCLK) disable iff (!RST_N)
		$fell(busy_r) |-> nap_r)
		else $error("No nap after the conversion ended.");
	a_nap_wake: assert property (@(posedge MCLK) disable iff (!RST_N)
		$rose(busy_r) |-> !nap_r)
		else $error("Still napping while busy.");
	a_oe_normal: assert property (@(posedge MCLK) disable iff (!RST_N)
		(!chain_s2_r && !rdl_s2_r) |=> oe_r)
		else $error("Output not driven with read enable low.");
	a_oe_release: assert property (@(posedge MCLK) disable iff (!RST_N)
		(!chain_s2_r && rdl_s2_r) |=> !oe_r)
		else $error("Output not released with read enable high.");
	a_chain_drive: assert property (@(posedge MCLK) disable iff (!RST_N)
		chain_s2_r |=> oe_r)
		else $error("Output not driven in chain mode.");
	a_msb_first: assert property (@(posedge MCLK) disable iff (!RST_N)
		(!busy_r && sck_cnt_r == 6'h00) |-> SDO_O == word_r[17])
		else $error("Top bit not presented first.");
	a_shift_order: assert property (@(posedge SCK) disable iff (!sck_clr_n)
		(sck_cnt_r == 6'h01) |-> SDO_O == word_r[16])
		else $error("Second bit not presented after first edge.");
endmodule : sacr_top

//--- tb/sacr_host_model.sv
// Host model: clocks the serial link and gathers the bits seen on the data line.
// Assumes the bench starts a frame only while BUSY is low and the line is driven.
`timescale 1ns/100ps
module sacr_host_model (
	// Serial link.
	output logic      sck,
	output logic      chain_in,
	input  wire logic sdo
);

	// ****************************************************************
	// Framing
	// ****************************************************************
	// The clock stands low outside frames, as a real host leaves it.
	initial
	begin
		sck      = 1'b0;
		chain_in = 1'b0;
	end

	// Samples the bit on show, then clocks n-1 rising edges, sampling as each clock falls.
	// The upstream chain bit changes while the clock is low, far from the edge.
	task automatic frame(input int n, input logic [17:0] cin, output logic [35:0] w);
		int k;
		w = '0;
		#19;
		for (k = 0; k < n; k++)
		begin
			w = {w[34:0], sdo};
			if (k == n - 1)
				break;
			chain_in = cin[17 - (k % 18)];
			#16 sck = 1'b1;
			#16 sck = 1'b0;
		end
		// A released line shows the inverse of its last bit, never a stale copy.
		chain_in = ~chain_in;
	endtask : frame

endmodule : sacr_host_model

//--- tb/sar_adc_convert_serial_readout_tb_top.sv
// Self-checking bench of the converter control and serial readout.
// Assumes the design top sacr_top and the host model sacr_host_model.
`timescale 1ns/100ps
module sar_adc_convert_serial_readout_tb_top;

	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic        mclk;
	logic        rst_n;
	logic        convert_strobe;
	logic        chain_sel;
	logic        read_en_n;
	logic        busy;
	logic        nap;
	logic [17:0] dac_code;
	logic [17:0] target;
	logic        sck;
	logic        chain_in;
	logic        sdo_o;
	logic        sdo_oe;
	wire         sdo_pin;
	wire         rdl_pin;
	wire         compare_in;
	int          num_errors;
	int          compares;
	int          i;
	logic [31:0] seed;
	logic [17:0] t;
	logic [17:0] corner [4] = '{18'h0_0000, 18'h3_FFFF, 18'h2_0000, 18'h1_FFFF};

	// The analog core: a held sample equal to target, comparator high at or above trial.
	assign compare_in = (target >= dac_code);
	assign rdl_pin    = chain_sel ? chain_in : read_en_n;
	// An undriven data line reads as z, so a released output never passes a compare.
	assign sdo_pin    = sdo_oe ? sdo_o : 1'bz;

	sacr_top dut (
		.MCLK                    (mclk),
		.RST_N                   (rst_n),
		.CONVERT_STROBE          (convert_strobe),
		.CHAIN_SELECT            (chain_sel),
		.READ_ENABLE_OR_CHAIN_IN (rdl_pin),
		.BUSY                    (busy),
		.NAP                     (nap),
		.COMPARE_IN              (compare_in),
		.CAPACITIVE_DAC_CODE     (dac_code),
		.SCK                     (sck),
		.SDO_O                   (sdo_o),
		.SDO_OE                  (sdo_oe)
	);

	sacr_host_model host (
		.sck      (sck),
		.chain_in (chain_in),
		.sdo      (sdo_pin)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Core clock at 100 MHz.
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	// One conversion; with twice set a second strobe lands mid-conversion and must be dropped.
	task automatic convert(input logic [17:0] tv, input logic twice);
		int k;
		int n;
		@(negedge mclk);
		target         = tv;
		convert_strobe = 1'b1;
		repeat (3) @(negedge mclk);
		convert_strobe = 1'b0;
		k = 0;
		while (busy !== 1'b1 && k < 20)
		begin
			@(negedge mclk);
			k++;
		end
		check("busy rise", 36'(busy), 36'h1);
		check("nap low", 36'(nap), 36'h0);
		n = 0;
		while (busy === 1'b1 && n < 200)
		begin
			@(negedge mclk);
			n++;
			if (twice && n == 10)
				convert_strobe = 1'b1;
			if (n == 14)
				convert_strobe = 1'b0;
		end
		check("conv length", 36'(n >= sacr_pkg::CONV_CYCLES), 36'h1);
		check("busy fall", 36'(busy), 36'h0);
		repeat (12) @(negedge mclk);
		check("no restart", 36'(busy), 36'h0);
		check("nap high", 36'(nap), 36'h1);
	endtask : convert

	// Reads the word just converted; in chain mode 18 upstream bits follow it.
	task automatic read_word(input logic [17:0] tv, input logic chain);
		logic [35:0] w;
		logic [17:0] cin;
		logic [17:0] code;
		seed = lfsr(seed);
		cin  = seed[17:0];
		code = tv ^ sacr_pkg::MSB_MASK;
		@(negedge mclk);
		read_en_n = chain;
		chain_sel = chain;
		repeat (4) @(negedge mclk);
		check("drive on", 36'(sdo_oe), 36'h1);
		host.frame(chain ? 36 : 18, cin, w);
		check("word", w, chain ? {code, cin} : {18'h0_0000, code});
		@(negedge mclk);
		read_en_n = 1'b1;
		chain_sel = 1'b0;
		repeat (4) @(negedge mclk);
		check("drive off", 36'(sdo_oe), 36'h0);
	endtask : read_word

	// ****************************************************************
	// Sequence
	// ****************************************************************
	// Corner codes first, then random codes; the last three reads use the chain.
	initial
	begin
		rst_n          = 1'b0;
		convert_strobe = 1'b0;
		chain_sel      = 1'b0;
		read_en_n      = 1'b1;
		target         = 18'h0_0000;
		seed           = 32'h0000_11f1;
		num_errors     = 0;
		compares       = 0;
		repeat (5) @(negedge mclk);
		rst_n = 1'b1;
		repeat (3) @(negedge mclk);
		check("nap reset", 36'(nap), 36'h1);
		for (i = 0; i < 12; i++)
		begin
			seed = lfsr(seed);
			t    = (i < 4) ? corner[i] : seed[17:0];
			convert(t, i[0]);
			read_word(t, i >= 9);
		end
		results();
	end

	// A hang is cut short well past the expected run of about 18 us.
	initial
	begin
		#200000;
		num_errors++;
		results();
	end

endmodule : sar_adc_convert_serial_readout_tb_top
